// ===== design/embi_bus_if.sv
// external memory and i/o bus sequencer with bus hand-over
`timescale 1ns/10ps
`include "embi_defs.svh"
// What this block does
// - address lines are driven in normal operation and floated while an outside master holds the bus.
// - a chip select goes low when an access falls inside its configured memory or i/o range and no lower numbered select also matches.
// - data lines are driven only in own write cycles and left floating for reads.
// - the i/o request strobe is low for i/o accesses, with read or write telling the kind.
// - the memory request strobe is low for memory accesses, with read, write and fetch telling the kind.
// - memory and i/o request lines float during reset and are inputs while the bus is granted away.
// - the read strobe is low while reading the presented address.
// - the write strobe is low while writing the presented address.
// - read and write strobes float for the whole time the bus is granted away; the fetch indicator has no enable and is driven high.
// - the fetch indicator goes low with memory request and read on an instruction fetch.
// - a low wait input from a slow part stretches the read or write while it stays low.
// - the non-maskable interrupt beats maskable ones and is taken at an instruction boundary regardless of enables.
// - on a bus hold request the address, data and control outputs float first, then the grant goes low.
// - the idle indicator goes low after a halt or sleep instruction.

module embi_bus_if
	import embi_pkg::*;
#(
	parameter int ADDR_W  = `EMBI_ADDR_W,
	parameter int DATA_W  = `EMBI_DATA_W,
	parameter int FIELD_W = `EMBI_SEL_FIELD_W
) (
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	input  wire logic                          reqValid,
	input  wire embi_kind_t                    reqKind,
	input  wire logic [ADDR_W-1:0]             reqAddr,
	input  wire logic [DATA_W-1:0]             reqWrData,
	output logic                               reqReady,
	output logic                               rspValid,
	output logic      [DATA_W-1:0]             rspData,
	input  wire logic [`EMBI_NUM_SEL-1:0]         selEnable,
	input  wire logic [`EMBI_NUM_SEL-1:0]         selIo,
	input  wire logic [`EMBI_NUM_SEL*FIELD_W-1:0] selLow,
	input  wire logic [`EMBI_NUM_SEL*FIELD_W-1:0] selHigh,
	input  wire logic [ADDR_W-1:0]             addrIn,
	output logic      [ADDR_W-1:0]             addrOut,
	output logic                               addrEnable_n,
	input  wire logic [DATA_W-1:0]             dataIn,
	output logic      [DATA_W-1:0]             dataOut,
	output logic                               dataEnable_n,
	output logic                               select0_n,
	output logic                               select1_n,
	output logic                               select2_n,
	output logic                               select3_n,
	input  wire logic                          memoryRequestIn_n,
	output logic                               memory_request_n,
	output logic                               memoryRequestEnable_n,
	input  wire logic                          ioRequestIn_n,
	output logic                               io_request_n,
	output logic                               ioRequestEnable_n,
	output logic                               readStrobe_n,
	output logic                               writeStrobe_n,
	output logic                               fetch_indicator_n,
	output logic                               strobeEnable_n,
	input  wire logic                          waitReq_n,
	input  wire logic                          bus_hold_request_n,
	output logic                               bus_hold_grant_n,
	input  wire logic                          nmi_n,
	input  wire logic                          irqReq,
	input  wire logic                          irqEnable,
	input  wire logic                          instrBoundary,
	output logic                               takeNmi,
	output logic                               takeIrq,
	input  wire logic                          haltInstruction,
	input  wire logic                          sleep_instruction,
	input  wire logic                          wakeEvent,
	output logic                               idle_indicator_n
);

	// ****************************************************************
	// helpers
	// ****************************************************************

	function automatic logic isWrite(input embi_kind_t k);
		return (k == K_MEM_WR) || (k == K_IO_WR);
	endfunction

	function automatic logic isIoKind(input embi_kind_t k);
		return (k == K_IO_RD) || (k == K_IO_WR);
	endfunction

	// ****************************************************************
	// sequencer state
	// ****************************************************************

	embi_state_t              state, next_state;
	embi_kind_t               kind, next_kind;
	logic [ADDR_W-1:0]        next_addrOut;
	logic [DATA_W-1:0]        next_dataOut, next_rspData;
	logic [`EMBI_NUM_SEL-1:0] selN, next_selN;
	logic                     next_addrEnable_n, next_dataEnable_n;
	logic                     next_memory_request_n, next_io_request_n;
	logic                     next_memoryRequestEnable_n;
	logic                     next_ioRequestEnable_n;
	logic                     next_readStrobe_n, next_writeStrobe_n;
	logic                     next_fetch_indicator_n, next_strobeEnable_n;
	logic                     next_bus_hold_grant_n;
	logic                     next_reqReady, next_rspValid;
	logic                     drive, access, accIo;
	logic                     csActive, csIo;
	logic [ADDR_W-1:0]        csAddr;
	logic [`EMBI_NUM_SEL-1:0] csSel_n;

	// while granted away the selects follow the outside master's bus
	assign csAddr   = (next_state == ST_GRANT) ? addrIn : next_addrOut;
	assign csIo     = (next_state == ST_GRANT) ? !ioRequestIn_n : accIo;
	assign csActive = (next_state == ST_GRANT) ?
		(!ioRequestIn_n || !memoryRequestIn_n) : access;

	embi_chip_select #(
		.ADDR_W  (ADDR_W),
		.NUM_SEL (`EMBI_NUM_SEL),
		.FIELD_W (FIELD_W)
	) u_select (
		.addr      (csAddr),
		.active    (csActive),
		.isIo      (csIo),
		.selEnable (selEnable),
		.selIo     (selIo),
		.selLow    (selLow),
		.selHigh   (selHigh),
		.sel_n     (csSel_n)
	);

	// next state and next pin levels; pins follow the next state so
	// every pin comes straight from a flop with no extra cycle of lag
	always_comb begin
		next_state    = state;
		next_kind     = kind;
		next_addrOut  = addrOut;
		next_dataOut  = dataOut;
		next_rspData  = rspData;
		next_rspValid = 1'h0;
		unique case (state)
			ST_IDLE: begin
				if (reqValid && reqReady) begin
					next_state   = ST_T1;
					next_kind    = reqKind;
					next_addrOut = reqAddr;
					next_dataOut = reqWrData;
				end else if (!bus_hold_request_n) begin
					next_state = ST_FLOAT;
				end
			end
			ST_T1:
				next_state = ST_T2;
			ST_T2: begin
				// stretched as long as the slow part holds wait low
				if (waitReq_n) begin
					next_state    = ST_IDLE;
					next_rspValid = 1'h1;
					if (!isWrite(kind))
						next_rspData = dataIn;
				end
			end
			ST_FLOAT:
				next_state = ST_GRANT;
			ST_GRANT: begin
				if (bus_hold_request_n)
					next_state = ST_RESUME;
			end
			ST_RESUME:
				next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase

		drive  = (next_state != ST_FLOAT) && (next_state != ST_GRANT);
		access = (next_state == ST_T1) || (next_state == ST_T2);
		accIo  = isIoKind(next_kind);

		next_addrEnable_n          = !drive;
		next_memoryRequestEnable_n = !drive;
		next_ioRequestEnable_n     = !drive;
		next_strobeEnable_n        = !drive;
		next_dataEnable_n = !(access && isWrite(next_kind));
		next_memory_request_n = !(access && !accIo);
		next_io_request_n     = !(access && accIo);
		next_readStrobe_n  = !(access && !isWrite(next_kind));
		next_writeStrobe_n = !(access && isWrite(next_kind));
		next_fetch_indicator_n = !(access && next_kind == K_FETCH);
		next_bus_hold_grant_n  = !(next_state == ST_GRANT);
		next_reqReady = (next_state == ST_IDLE);
		next_selN     = csSel_n;
	end

	// register the sequencer; reset floats every shared line
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state                 <= ST_IDLE;
			kind                  <= K_MEM_RD;
			addrOut               <= `EMBI_ADDR_RESET;
			dataOut               <= `EMBI_DATA_RESET;
			rspData               <= `EMBI_DATA_RESET;
			rspValid              <= 1'h0;
			reqReady              <= 1'h0;
			selN                  <= `EMBI_SEL_NONE;
			addrEnable_n          <= `EMBI_INACTIVE;
			dataEnable_n          <= `EMBI_INACTIVE;
			memoryRequestEnable_n <= `EMBI_INACTIVE;
			ioRequestEnable_n     <= `EMBI_INACTIVE;
			strobeEnable_n        <= `EMBI_INACTIVE;
			memory_request_n      <= `EMBI_INACTIVE;
			io_request_n          <= `EMBI_INACTIVE;
			readStrobe_n          <= `EMBI_INACTIVE;
			writeStrobe_n         <= `EMBI_INACTIVE;
			fetch_indicator_n     <= `EMBI_INACTIVE;
			bus_hold_grant_n      <= `EMBI_INACTIVE;
		end else begin
			state                 <= next_state;
			kind                  <= next_kind;
			addrOut               <= next_addrOut;
			dataOut               <= next_dataOut;
			rspData               <= next_rspData;
			rspValid              <= next_rspValid;
			reqReady              <= next_reqReady;
			selN                  <= next_selN;
			addrEnable_n          <= next_addrEnable_n;
			dataEnable_n          <= next_dataEnable_n;
			memoryRequestEnable_n <= next_memoryRequestEnable_n;
			ioRequestEnable_n     <= next_ioRequestEnable_n;
			strobeEnable_n        <= next_strobeEnable_n;
			memory_request_n      <= next_memory_request_n;
			io_request_n          <= next_io_request_n;
			readStrobe_n          <= next_readStrobe_n;
			writeStrobe_n         <= next_writeStrobe_n;
			fetch_indicator_n     <= next_fetch_indicator_n;
			bus_hold_grant_n      <= next_bus_hold_grant_n;
		end
	end

	assign select0_n = selN[0];
	assign select1_n = selN[1];
	assign select2_n = selN[2];
	assign select3_n = selN[3];

	// ****************************************************************
	// interrupt arbitration and idle indicator
	// ****************************************************************

	logic nmiPrev, next_nmiPrev, nmiPending, next_nmiPending;
	logic next_takeNmi, next_takeIrq, next_idle_indicator_n;

	// nmi is edge-caught so a long low level is taken only once; a new
	// edge in the cycle it is taken keeps the pending flag set
	always_comb begin
		next_nmiPrev    = nmi_n;
		next_nmiPending = nmiPending;
		next_takeNmi    = 1'h0;
		next_takeIrq    = 1'h0;
		if (instrBoundary) begin
			if (nmiPending) begin
				next_takeNmi    = 1'h1;
				next_nmiPending = 1'h0;
			end else if (irqReq && irqEnable) begin
				next_takeIrq = 1'h1;
			end
		end
		if (nmiPrev && !nmi_n)
			next_nmiPending = 1'h1;
		// entry into halt or sleep beats a wake in the same cycle
		next_idle_indicator_n = idle_indicator_n;
		if (wakeEvent)
			next_idle_indicator_n = `EMBI_INACTIVE;
		if (haltInstruction || sleep_instruction)
			next_idle_indicator_n = `EMBI_ACTIVE;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			nmiPrev          <= `EMBI_INACTIVE;
			nmiPending       <= 1'h0;
			takeNmi          <= 1'h0;
			takeIrq          <= 1'h0;
			idle_indicator_n <= `EMBI_INACTIVE;
		end else begin
			nmiPrev          <= next_nmiPrev;
			nmiPending       <= next_nmiPending;
			takeNmi          <= next_takeNmi;
			takeIrq          <= next_takeIrq;
			idle_indicator_n <= next_idle_indicator_n;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_addr_float_grant: assert property (
		!bus_hold_grant_n |-> addrEnable_n)
		else $error("address driven while bus granted");
	a_select_in_access: assert property (
		(selN != `EMBI_SEL_NONE && bus_hold_grant_n) |->
		(!memory_request_n || !io_request_n) && $onehot0(~selN))
		else $error("chip select outside an access");
	a_data_write_only: assert property (
		!dataEnable_n |-> !writeStrobe_n && readStrobe_n)
		else $error("data driven outside a write");
	a_io_kind: assert property (
		!io_request_n |-> memory_request_n &&
		(readStrobe_n != writeStrobe_n))
		else $error("io request without one strobe");
	a_mem_kind: assert property (
		!memory_request_n |-> readStrobe_n != writeStrobe_n)
		else $error("memory request without one strobe");
	a_req_float_grant: assert property (
		!bus_hold_grant_n |->
		memoryRequestEnable_n && ioRequestEnable_n)
		else $error("request lines driven while granted");
	a_read_stretch: assert property (
		(state == ST_T1 && !isWrite(kind)) |->
		!readStrobe_n ##1 !readStrobe_n)
		else $error("read strobe not held");
	a_write_strobe: assert property (
		(state == ST_T1 && isWrite(kind)) |->
		!writeStrobe_n && !dataEnable_n)
		else $error("write strobe missing");
	a_strobe_float: assert property (
		!bus_hold_grant_n |-> strobeEnable_n)
		else $error("strobes driven while granted");
	a_fetch_with_read: assert property (
		!fetch_indicator_n |-> !memory_request_n && !readStrobe_n)
		else $error("fetch indicator without memory read");
	a_wait_extends: assert property (
		(state == ST_T2 && !waitReq_n) |=>
		state == ST_T2 && !rspValid)
		else $error("access ended while wait low");
	a_wait_release: assert property (
		(state == ST_T2 && waitReq_n) |=>
		rspValid && memory_request_n && io_request_n ##1 !rspValid)
		else $error("access not ended after wait high");
	a_nmi_priority: assert property (
		(instrBoundary && nmiPending) |=> takeNmi && !takeIrq)
		else $error("nmi not taken first");
	a_float_then_grant: assert property (
		(state == ST_IDLE && !bus_hold_request_n && !(reqValid && reqReady))
		|=> addrEnable_n && bus_hold_grant_n ##1 !bus_hold_grant_n)
		else $error("grant not preceded by float");
	a_idle_indicator: assert property (
		(haltInstruction || sleep_instruction) |=> !idle_indicator_n)
		else $error("idle indicator not low");
	a_release_order: assert property (
		$rose(bus_hold_grant_n) |-> !addrEnable_n && reqReady == 1'h0
		##1 reqReady)
		else $error("bus not resumed before next cycle");

	c_read_waited: cover property (
		(state == ST_T2 && !waitReq_n) ##[1:8] rspValid);
	c_fetch: cover property (!fetch_indicator_n);
	c_io_write: cover property (!io_request_n && !writeStrobe_n);
	c_bus_granted: cover property (
		!bus_hold_grant_n ##[1:20] bus_hold_grant_n);
	c_nmi_taken: cover property (takeNmi);

endmodule

// ===== design/embi_chip_select.sv
// address range decoder that builds the active-low chip selects
`timescale 1ns/10ps
`include "embi_defs.svh"

module embi_chip_select #(
	parameter int ADDR_W  = `EMBI_ADDR_W,
	parameter int NUM_SEL = `EMBI_NUM_SEL,
	parameter int FIELD_W = `EMBI_SEL_FIELD_W
) (
	input  wire logic [ADDR_W-1:0]          addr,
	input  wire logic                       active,
	input  wire logic                       isIo,
	input  wire logic [NUM_SEL-1:0]         selEnable,
	input  wire logic [NUM_SEL-1:0]         selIo,
	input  wire logic [NUM_SEL*FIELD_W-1:0] selLow,
	input  wire logic [NUM_SEL*FIELD_W-1:0] selHigh,
	output logic      [NUM_SEL-1:0]         sel_n
);

	// ****************************************************************
	// range compare
	// ****************************************************************

	// memory ranges look at the top byte, i/o ranges at the port byte;
	// the lowest numbered select wins so only one ever goes low
	always_comb begin
		logic [FIELD_W-1:0] slice;
		logic               hit;
		slice = isIo ? addr[`EMBI_IO_SEL_LSB +: FIELD_W]
			: addr[`EMBI_MEM_SEL_LSB +: FIELD_W];
		hit   = 1'h0;
		sel_n = '1;
		for (int i = 0; i < NUM_SEL; i++) begin
			if (!hit && active && selEnable[i] && (selIo[i] == isIo) &&
				slice >= selLow[i*FIELD_W +: FIELD_W] &&
				slice <= selHigh[i*FIELD_W +: FIELD_W]) begin
				sel_n[i] = `EMBI_ACTIVE;
				hit      = 1'h1;
			end
		end
	end

endmodule

// ===== design/embi_defs.svh
// constants for the external memory bus interface
`ifndef EMBI_DEFS_SVH
`define EMBI_DEFS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define EMBI_ADDR_W        24
`define EMBI_DATA_W        8
`define EMBI_NUM_SEL       4
`define EMBI_SEL_FIELD_W   8

// ****************************************************************
// field positions of the address slice compared by the selects
// ****************************************************************
`define EMBI_MEM_SEL_LSB   16
`define EMBI_IO_SEL_LSB    8

// ****************************************************************
// reset values and levels
// ****************************************************************
`define EMBI_INACTIVE      1'h1
`define EMBI_ACTIVE        1'h0
`define EMBI_SEL_NONE      4'hF
`define EMBI_ADDR_RESET    24'h00_0000
`define EMBI_DATA_RESET    8'h00

// ****************************************************************
// timing: least reset hold of the reset source, in clock cycles
// ****************************************************************
`define EMBI_RST_MIN_CYCLES 3

`endif

// ===== design/embi_pkg.sv
// types shared by the external memory bus interface
package embi_pkg;

	// bus sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_T1,
		ST_T2,
		ST_FLOAT,
		ST_GRANT,
		ST_RESUME
	} embi_state_t;

	// kind of access asked for by the core
	typedef enum logic [2:0] {
		K_MEM_RD,
		K_FETCH,
		K_MEM_WR,
		K_IO_RD,
		K_IO_WR
	} embi_kind_t;

endpackage

// ===== sim/embi_bus_if_tb_top.sv
// self-checking testbench for the external memory bus sequencer
`timescale 1ns/10ps

module embi_bus_if_tb_top
	import embi_pkg::*;
;
	// ************************************************************
	// signals and pin wiring
	// ************************************************************
	logic        clk, sys_rst, reqValid, reqReady, rspValid, extDrive;
	embi_kind_t  reqKind;
	logic [23:0] reqAddr, addrIn, addrOut, extAddr;
	logic [7:0]  reqWrData, rspData, dataIn, dataOut, memData;
	logic [3:0]  selN;
	logic [2:0]  waitCycles;
	logic        addrEnable_n, dataEnable_n, extMemReq_n, rdWire, wrWire;
	logic        select0_n, select1_n, select2_n, select3_n;
	logic        memoryRequestIn_n, memory_request_n, memoryRequestEnable_n;
	logic        ioRequestIn_n, io_request_n, ioRequestEnable_n;
	logic        readStrobe_n, writeStrobe_n, fetch_indicator_n;
	logic        strobeEnable_n, waitReq_n, bus_hold_request_n;
	logic        bus_hold_grant_n, nmi_n, irqReq, irqEnable, instrBoundary;
	logic        takeNmi, takeIrq, haltInstruction, sleep_instruction;
	logic        wakeEvent, idle_indicator_n;
	int          errorCnt, checkCount;

	// pin levels from every party's enable; released lines float high
	// except the address and data, which show a changing pattern
	assign addrIn = addrEnable_n ? (extDrive ? extAddr : ~addrOut) : addrOut;
	assign dataIn = dataEnable_n ? memData : dataOut;
	assign memoryRequestIn_n = memoryRequestEnable_n ? extMemReq_n
		: memory_request_n;
	assign ioRequestIn_n = ioRequestEnable_n ? 1'b1 : io_request_n;
	assign rdWire = strobeEnable_n ? 1'b1 : readStrobe_n;
	assign wrWire = strobeEnable_n ? 1'b1 : writeStrobe_n;
	assign selN = {select3_n, select2_n, select1_n, select0_n};

	// select 0 mem 10-1f, select 1 i/o 20-2f, select 2 mem 00-ff,
	// select 3 i/o 90-9f so every select pin is seen low once
	embi_bus_if dut (
		.clk(clk), .sys_rst(sys_rst), .reqValid(reqValid),
		.reqKind(reqKind), .reqAddr(reqAddr), .reqWrData(reqWrData),
		.reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
		.selEnable(4'hF), .selIo(4'hA), .selLow(32'h9000_2010),
		.selHigh(32'h9FFF_2F1F), .addrIn(addrIn), .addrOut(addrOut),
		.addrEnable_n(addrEnable_n), .dataIn(dataIn), .dataOut(dataOut),
		.dataEnable_n(dataEnable_n), .select0_n(select0_n),
		.select1_n(select1_n), .select2_n(select2_n),
		.select3_n(select3_n), .memoryRequestIn_n(memoryRequestIn_n),
		.memory_request_n(memory_request_n),
		.memoryRequestEnable_n(memoryRequestEnable_n),
		.ioRequestIn_n(ioRequestIn_n), .io_request_n(io_request_n),
		.ioRequestEnable_n(ioRequestEnable_n),
		.readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
		.fetch_indicator_n(fetch_indicator_n),
		.strobeEnable_n(strobeEnable_n), .waitReq_n(waitReq_n),
		.bus_hold_request_n(bus_hold_request_n),
		.bus_hold_grant_n(bus_hold_grant_n), .nmi_n(nmi_n),
		.irqReq(irqReq), .irqEnable(irqEnable),
		.instrBoundary(instrBoundary), .takeNmi(takeNmi),
		.takeIrq(takeIrq), .haltInstruction(haltInstruction),
		.sleep_instruction(sleep_instruction), .wakeEvent(wakeEvent),
		.idle_indicator_n(idle_indicator_n)
	);

	embi_mem_model partner (
		.clk(clk), .addrLow(addrIn[3:0]), .readStrobe_n(rdWire),
		.writeStrobe_n(wrWire), .busData(dataIn), .waitCycles(waitCycles),
		.driveData(memData), .waitReq_n(waitReq_n)
	);

	// ************************************************************
	// checking and scenario tasks
	// ************************************************************
	task automatic chk(input string name, input logic [31:0] exp,
			input logic [31:0] got);
		checkCount++;
		if (got !== exp) begin
			errorCnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", checkCount, errorCnt);
		if (errorCnt == 0 && checkCount > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// one core access; checks the pins in the first cycle and the length
	task automatic access(input embi_kind_t kind, input logic [23:0] addr,
			input logic [7:0] wdata, input logic [2:0] waits,
			input logic [3:0] expSel, input logic [7:0] expRd);
		int n = 0;
		logic isWr = (kind == K_MEM_WR) || (kind == K_IO_WR);
		logic isIo = (kind == K_IO_RD) || (kind == K_IO_WR);
		@(posedge clk);
		reqValid <= 1'b1;
		reqKind <= kind;
		reqAddr <= addr;
		reqWrData <= wdata;
		waitCycles <= waits;
		do begin
			@(posedge clk);
			n++;
		end while (reqReady !== 1'b1 && n < 20);
		reqValid <= 1'b0;
		#1;
		chk("addrOut", addr, addrOut);
		chk("addrEnable_n", 1'b0, addrEnable_n);
		chk("selects", expSel, selN);
		chk("memory_request_n", isIo, memory_request_n);
		chk("io_request_n", !isIo, io_request_n);
		chk("readStrobe_n", isWr, readStrobe_n);
		chk("writeStrobe_n", !isWr, writeStrobe_n);
		chk("fetch_indicator_n", kind != K_FETCH, fetch_indicator_n);
		chk("dataEnable_n", !isWr, dataEnable_n);
		if (isWr) chk("dataOut", wdata, dataOut);
		n = 0;
		while (rspValid !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("access cycles", 2 + waits, n);
		chk("strobes and selects", 6'h3F, {readStrobe_n, writeStrobe_n,
			selN});
		if (!isWr) chk("rspData", expRd, rspData);
	endtask

	// outside master takes the bus, decodes a select, then hands back
	task automatic bus_hold();
		@(posedge clk);
		bus_hold_request_n <= 1'b0;
		@(posedge clk);
		#1;
		chk("float then grant", 6'h3F, {addrEnable_n, dataEnable_n,
			memoryRequestEnable_n, ioRequestEnable_n, strobeEnable_n,
			bus_hold_grant_n});
		@(posedge clk);
		extDrive <= 1'b1;
		extAddr <= 24'h13_0000;
		extMemReq_n <= 1'b0;
		#1;
		chk("bus_hold_grant_n", 1'b0, bus_hold_grant_n);
		@(posedge clk);
		#1;
		chk("selects while granted", 4'hE, selN);
		chk("floating while granted", 5'h1F, {addrEnable_n, strobeEnable_n,
			memoryRequestEnable_n, ioRequestEnable_n,
			dataEnable_n});
		chk("reqReady while granted", 1'b0, reqReady);
		@(posedge clk);
		bus_hold_request_n <= 1'b1;
		extDrive <= 1'b0;
		extMemReq_n <= 1'b1;
		@(posedge clk);
		#1;
		chk("resume", 5'h10, {bus_hold_grant_n, addrEnable_n,
			memoryRequestEnable_n, ioRequestEnable_n,
			strobeEnable_n});
		chk("reqReady on resume", 1'b0, reqReady);
		@(posedge clk);
		#1;
		chk("reqReady after resume", 1'b1, reqReady);
	endtask

	// masked irq refused, enabled irq taken, nmi beats an enabled irq
	task automatic interrupts();
		@(posedge clk);
		irqReq <= 1'b1;
		instrBoundary <= 1'b1;
		@(posedge clk);
		irqEnable <= 1'b1;
		#1;
		chk("masked irq", 2'b00, {takeNmi, takeIrq});
		@(posedge clk);
		instrBoundary <= 1'b0;
		nmi_n <= 1'b0;
		#1;
		chk("enabled irq", 2'b01, {takeNmi, takeIrq});
		@(posedge clk);
		instrBoundary <= 1'b1;
		@(posedge clk);
		instrBoundary <= 1'b0;
		nmi_n <= 1'b1;
		#1;
		chk("nmi first", 2'b10, {takeNmi, takeIrq});
		@(posedge clk);
		irqReq <= 1'b0;
		#1;
		chk("no take off boundary", 2'b00, {takeNmi, takeIrq});
	endtask

	// halt then sleep each pull the indicator low until a wake event
	task automatic idle_modes();
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			haltInstruction <= (k == 0);
			sleep_instruction <= (k == 1);
			@(posedge clk);
			haltInstruction <= 1'b0;
			sleep_instruction <= 1'b0;
			#1;
			chk("idle entry", 1'b0, idle_indicator_n);
			@(posedge clk);
			wakeEvent <= 1'b1;
			@(posedge clk);
			wakeEvent <= 1'b0;
			#1;
			chk("idle exit", 1'b1, idle_indicator_n);
		end
	endtask

	// ************************************************************
	// clock, watchdog and main sequence
	// ************************************************************
	initial clk = 1'b0;
	always #5 clk = ~clk;

	// the whole run is well under 1000 cycles
	initial begin
		#100us;
		errorCnt++;
		$display("watchdog expired");
		stop_test();
	end

	initial begin
		{sys_rst, reqValid, extDrive, irqReq, irqEnable} = 5'h10;
		{instrBoundary, haltInstruction, sleep_instruction} = 3'h0;
		{extMemReq_n, bus_hold_request_n, nmi_n, wakeEvent} = 4'hE;
		reqKind = K_MEM_RD;
		{reqAddr, reqWrData} = 32'h0000_0000;
		{extAddr, waitCycles} = 27'h000_0000;
		errorCnt = 0;
		checkCount = 0;
		repeat (2) @(posedge clk);
		#1;
		chk("float in reset", 7'h7E, {addrEnable_n, dataEnable_n,
			memoryRequestEnable_n, ioRequestEnable_n, strobeEnable_n,
			bus_hold_grant_n, reqReady});
		@(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("driving after reset", 4'h0, {addrEnable_n,
			memoryRequestEnable_n, ioRequestEnable_n,
			strobeEnable_n});
		access(K_MEM_RD, 24'h12_0005, 8'h00, 3'h0, 4'hE, 8'hA5);
		access(K_FETCH, 24'h40_0003, 8'h00, 3'h1, 4'hB, 8'hA3);
		access(K_MEM_WR, 24'h15_0002, 8'h3C, 3'h2, 4'hE, 8'h00);
		access(K_MEM_RD, 24'h12_0002, 8'h00, 3'h0, 4'hE, 8'h3C);
		access(K_IO_WR, 24'h00_2507, 8'h5A, 3'h0, 4'hD, 8'h00);
		access(K_IO_RD, 24'h00_9907, 8'h00, 3'h3, 4'h7, 8'h5A);
		bus_hold();
		interrupts();
		idle_modes();
		stop_test();
	end
endmodule

// ===== sim/embi_mem_model.sv
// external memory or peripheral model with wait-state insertion
`timescale 1ns/10ps

module embi_mem_model (
	input  wire logic       clk,
	input  wire logic [3:0] addrLow,
	input  wire logic       readStrobe_n,
	input  wire logic       writeStrobe_n,
	input  wire logic [7:0] busData,
	input  wire logic [2:0] waitCycles,
	output logic      [7:0] driveData,
	output logic            waitReq_n
);
	logic [7:0] mem [16];
	logic [7:0] lastData;
	logic [3:0] lastAddr;
	logic [2:0] seen;
	logic       wrLow;

	// ramp contents so the bench can predict reads without peeking here
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = 8'hA0 + 8'(i);
		end
		lastData = 8'h00;
		lastAddr = 4'h0;
		seen = 3'h0;
		wrLow = 1'b0;
	end

	// slow part: hold wait low for waitCycles samples of each access
	assign waitReq_n = !((!readStrobe_n || !writeStrobe_n) &&
		(seen < waitCycles + 3'h1));

	// count strobe cycles and commit a write when its strobe rises
	always @(posedge clk) begin
		if (!readStrobe_n || !writeStrobe_n) begin
			if (seen != 3'h7) begin
				seen <= seen + 3'h1;
			end
		end else begin
			seen <= 3'h0;
		end
		if (!writeStrobe_n) begin
			lastData <= busData;
			lastAddr <= addrLow;
		end
		if (wrLow && writeStrobe_n) begin
			mem[lastAddr] <= lastData;
		end
		wrLow <= !writeStrobe_n;
	end

	// drive only under the read strobe; otherwise a changing pattern,
	// since an undriven bus keeps no value
	assign driveData = readStrobe_n ? ~mem[addrLow] : mem[addrLow];
endmodule
